/* pkg/bank_consts.svh */
// Purpose: Offsets, fields, reset values and timing counts of the housekeeping register bank
// Assumes: 12-bit register addresses, 8-bit register data
// Notes: Included by the package and by both ends
`ifndef BANK_CONSTS_SVH
`define BANK_CONSTS_SVH

`define ADDR_W 12
`define DATA_W 8

`define OFS_CONVERTER_CONTROL 12'h302
`define OFS_CONVERTER_STATUS 12'h303
`define OFS_CONVERTER_RESULT 12'h304
`define OFS_PIN_OUTPUT_VALUES 12'h305
`define OFS_PIN_INPUT_VALUES 12'h306
`define OFS_PIN_DIRECTION_LEVEL 12'h307
`define OFS_IF_AMP_BIAS 12'h308
`define OFS_RF_DRIVER_BIAS 12'h309
`define OFS_LO_AMP_BIAS 12'h30A
`define OFS_DETECTOR_TRIM 12'h30C
`define OFS_MIXER_BIAS_POS 12'h30D
`define OFS_MIXER_BIAS_NEG 12'h30E

`define RST_CONVERTER_CONTROL 8'hCA
`define RST_CONVERTER_RESULT 8'hEF
`define RST_PIN_OUTPUT_VALUES 8'h00
`define RST_PIN_INPUT_FIELD 3'h7
`define RST_PIN_DIRECTION_LEVEL 8'h00
`define RST_IF_AMP_BIAS 8'h08
`define RST_RF_DRIVER_BIAS 8'h88
`define RST_LO_AMP_BIAS 8'h88
`define RST_DETECTOR_TRIM 8'h00
`define RST_MIXER_BIAS_POS 8'h08
`define RST_MIXER_BIAS_NEG 8'h08

// Writable bits per register; the other bits of these registers read zero
`define WMASK_CONVERTER_CONTROL 8'hFF
`define WMASK_PIN_OUTPUT_VALUES 8'h0E
`define WMASK_PIN_DIRECTION_LEVEL 8'h7E
`define WMASK_IF_AMP_BIAS 8'h0F
`define WMASK_RF_DRIVER_BIAS 8'hFF
`define WMASK_LO_AMP_BIAS 8'hFF
`define WMASK_DETECTOR_TRIM 8'h1F
`define WMASK_MIXER_BIAS 8'h1F

// Converter control fields
`define CTL_DIV_HI 7
`define CTL_DIV_LO 4
`define CTL_LOG_BIT 3
`define CTL_HALF_BIT 2
`define CTL_START_BIT 1
`define CTL_EN_BIT 0

// Converter status fields
`define STS_READY_BIT 2
`define STS_BUSY_BIT 1
`define STS_EOC_BIT 0

// Pin fields
`define PIN_VAL_HI 3
`define PIN_VAL_LO 1
`define PIN_DIR_HI 6
`define PIN_DIR_LO 4
`define PIN_LVL_HI 3
`define PIN_LVL_LO 1

// Converter clock is ref/(2*divider); one conversion lasts this many converter clocks
`define CONV_CLOCK_RATIO 2
`define CONV_CYCLES 4'h8

`endif

/* pkg/bank_pkg.sv */
// Purpose: Types shared by the two ends of the register bank link
// Assumes: bank_consts.svh holds all numbers
// Notes: Nothing here is imported; users write bank_pkg::name
`include "bank_consts.svh"
`default_nettype none

package bank_pkg;

	typedef enum logic {
		CONV_IDLE = 1'b0,
		CONV_BUSY = 1'b1
	} conv_state_t;

	typedef enum logic {
		HOST_IDLE = 1'b0,
		HOST_WAIT = 1'b1
	} host_state_t;

	typedef logic [`ADDR_W-1:0] reg_addr_t;
	typedef logic [`DATA_W-1:0] reg_data_t;

endpackage

`default_nettype wire

/* pkg/bank_if.sv */
// Purpose: Register access link between the host end and the device end
// Assumes: One clock shared by both ends
// Notes: One write or read per request cycle; read data returns one cycle later
`include "bank_consts.svh"
`default_nettype none

interface bank_if;
	logic wr_en;
	logic rd_en;
	logic [`ADDR_W-1:0] addr;
	logic [`DATA_W-1:0] wdata;
	logic [`DATA_W-1:0] rdata;
	logic rvalid;

	modport device (input wr_en, input rd_en, input addr, input wdata, output rdata, output rvalid);
	modport host (output wr_en, output rd_en, output addr, output wdata, input rdata, input rvalid);
endinterface

`default_nettype wire

/* hdl/bank_host.sv */
// Purpose: Host end; turns user commands into single register accesses on the link
// Assumes: Device answers a read exactly one cycle after taking it
// Notes: Recommended bias settings and the start sequence are the user's job
`include "bank_consts.svh"
`default_nettype none

module bank_host (
	input wire logic ref_clk_i,
	input wire logic rst_i,
	bank_if.host bus,
	input wire logic cmd_valid_i,
	input wire logic cmd_write_i,
	input wire logic [`ADDR_W-1:0] cmd_addr_i,
	input wire logic [`DATA_W-1:0] cmd_wdata_i,
	output logic cmd_ready_o,
	output logic rsp_valid_o,
	output logic [`DATA_W-1:0] rsp_data_o
);
	// Start must go 0 then 1 after enable is set
	// Bias fields are left to the user: are software settings

	bank_pkg::host_state_t state_q, state_d;
	logic wr_q, rd_q;
	logic [`ADDR_W-1:0] addr_q;
	logic [`DATA_W-1:0] wdata_q, rsp_data_q;
	logic rsp_valid_q;

	wire take_cmd = cmd_valid_i & (state_q == bank_pkg::HOST_IDLE);

	assign cmd_ready_o = (state_q == bank_pkg::HOST_IDLE);
	assign bus.wr_en = wr_q;
	assign bus.rd_en = rd_q;
	assign bus.addr = addr_q;
	assign bus.wdata = wdata_q;
	assign rsp_valid_o = rsp_valid_q;
	assign rsp_data_o = rsp_data_q;

	always_comb begin
		state_d = state_q;
		case (state_q)
			bank_pkg::HOST_IDLE: begin
				if (take_cmd && !cmd_write_i) begin
					state_d = bank_pkg::HOST_WAIT;
				end
			end
			bank_pkg::HOST_WAIT: begin
				if (bus.rvalid) begin
					state_d = bank_pkg::HOST_IDLE;
				end
			end
			default: state_d = bank_pkg::HOST_IDLE;
		endcase
	end

	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			state_q <= bank_pkg::HOST_IDLE;
			wr_q <= 1'b0;
			rd_q <= 1'b0;
			addr_q <= '0;
			wdata_q <= '0;
			rsp_valid_q <= 1'b0;
			rsp_data_q <= '0;
		end else begin
			state_q <= state_d;
			wr_q <= take_cmd & cmd_write_i;
			rd_q <= take_cmd & ~cmd_write_i;
			if (take_cmd) begin
				addr_q <= cmd_addr_i;
				wdata_q <= cmd_wdata_i;
			end
			rsp_valid_q <= (state_q == bank_pkg::HOST_WAIT) & bus.rvalid;
			if ((state_q == bank_pkg::HOST_WAIT) && bus.rvalid) begin
				rsp_data_q <= bus.rdata;
			end
		end
	end
endmodule

`default_nettype wire

/* hdl/bank_device.sv */
// Purpose: Device end; register bank with housekeeping converter control and three general pins
// Assumes: Link requests and pin inputs are synchronous to ref_clk_i
// Notes: Converter is modelled digitally on the sampled input word
`include "bank_consts.svh"
`default_nettype none

module bank_device (
	input wire logic ref_clk_i,
	input wire logic rst_i,
	bank_if.device bus,
	input wire logic [`DATA_W-1:0] conv_sample_i,
	input wire logic [2:0] pin_in_i,
	output logic [2:0] pin_out_o,
	output logic [2:0] pin_oe_n_o,
	output logic [2:0] pin_level_18v_o,
	output logic [4:0] detector_cal_trim_o,
	output logic [3:0] if_amp_bias_level_o,
	output logic [3:0] rf_output_driver_bias_o,
	output logic [3:0] rf_predriver_bias_o,
	output logic [3:0] lo_amp_bias_first_o,
	output logic [3:0] lo_amp_bias_second_o,
	output logic [4:0] mixer_bias_positive_o,
	output logic [4:0] mixer_bias_negative_o
);

	// Log scale: three-bit exponent above five mantissa bits below the leading one
	function automatic logic [7:0] log_scale(input logic [7:0] x);
		logic [2:0] msb;
		logic [7:0] norm;
		msb = 3'h0;
		norm = 8'h00;
		for (int i = 0; i < 8; i++) begin
			if (x[i]) begin
				msb = 3'(i);
			end
		end
		norm = x << (3'h7 - msb);
		log_scale = (x == 8'h00) ? 8'h00 : {msb, norm[6:2]};
	endfunction

	function automatic logic [7:0] masked_write(input logic [7:0] old, input logic [7:0] val,
		input logic [7:0] mask);
		masked_write = (old & ~mask) | (val & mask);
	endfunction

	// Writable registers
	logic [7:0] ctl_q;
	logic [7:0] pin_out_q;
	logic [7:0] pin_cfg_q;
	logic [7:0] if_bias_q;
	logic [7:0] rf_bias_q;
	logic [7:0] lo_bias_q;
	logic [7:0] det_trim_q;
	logic [7:0] mix_pos_q;
	logic [7:0] mix_neg_q;

	// Device state
	logic [7:0] result_q;
	logic [2:0] pin_in_q;
	logic ready_q;
	logic start_prev_q;
	logic [7:0] sample_q;
	logic [4:0] div_cnt_q;
	logic [3:0] conv_cnt_q;
	bank_pkg::conv_state_t conv_q, conv_d;
	logic [7:0] rdata_q;
	logic rvalid_q;

	// Link decode
	wire wr_ctl = bus.wr_en && (bus.addr == `OFS_CONVERTER_CONTROL);
	wire wr_pin_out = bus.wr_en && (bus.addr == `OFS_PIN_OUTPUT_VALUES);
	wire wr_pin_cfg = bus.wr_en && (bus.addr == `OFS_PIN_DIRECTION_LEVEL);
	wire wr_if_bias = bus.wr_en && (bus.addr == `OFS_IF_AMP_BIAS);
	wire wr_rf_bias = bus.wr_en && (bus.addr == `OFS_RF_DRIVER_BIAS);
	wire wr_lo_bias = bus.wr_en && (bus.addr == `OFS_LO_AMP_BIAS);
	wire wr_det = bus.wr_en && (bus.addr == `OFS_DETECTOR_TRIM);
	wire wr_mix_pos = bus.wr_en && (bus.addr == `OFS_MIXER_BIAS_POS);
	wire wr_mix_neg = bus.wr_en && (bus.addr == `OFS_MIXER_BIAS_NEG);

	// Converter control fields
	wire [3:0] div_field = ctl_q[`CTL_DIV_HI:`CTL_DIV_LO];
	wire log_on = ctl_q[`CTL_LOG_BIT];
	wire half_on = ctl_q[`CTL_HALF_BIT];
	wire start_bit = ctl_q[`CTL_START_BIT];
	wire conv_en = ctl_q[`CTL_EN_BIT];

	wire start_rise = start_bit & ~start_prev_q;
	wire conv_go = start_rise & conv_en & (conv_q == bank_pkg::CONV_IDLE);

	// A zero divider would stop the clock, so it counts as one
	wire [3:0] div_eff = (div_field == 4'h0) ? 4'h1 : div_field;
	wire [4:0] div_last = 5'(div_eff * `CONV_CLOCK_RATIO) - 5'h01;
	wire conv_tick = (conv_q == bank_pkg::CONV_BUSY) && (div_cnt_q == div_last);
	wire conv_done = conv_tick && (conv_cnt_q == `CONV_CYCLES - 4'h1);

	wire [7:0] conv_input = half_on ? {1'b0, sample_q[7:1]} : sample_q;
	wire [7:0] conv_value = log_on ? log_scale(conv_input) : conv_input;

	wire busy = (conv_q == bank_pkg::CONV_BUSY);
	wire [7:0] status_word = {5'h00, ready_q, busy, ~busy};

	// Read selection; unmapped and reserved bits read zero
	wire [7:0] rd_mux =
		(bus.addr == `OFS_CONVERTER_CONTROL) ? ctl_q :
		(bus.addr == `OFS_CONVERTER_STATUS) ? status_word :
		(bus.addr == `OFS_CONVERTER_RESULT) ? result_q :
		(bus.addr == `OFS_PIN_OUTPUT_VALUES) ? pin_out_q :
		(bus.addr == `OFS_PIN_INPUT_VALUES) ? {4'h0, pin_in_q, 1'b0} :
		(bus.addr == `OFS_PIN_DIRECTION_LEVEL) ? pin_cfg_q :
		(bus.addr == `OFS_IF_AMP_BIAS) ? if_bias_q :
		(bus.addr == `OFS_RF_DRIVER_BIAS) ? rf_bias_q :
		(bus.addr == `OFS_LO_AMP_BIAS) ? lo_bias_q :
		(bus.addr == `OFS_DETECTOR_TRIM) ? det_trim_q :
		(bus.addr == `OFS_MIXER_BIAS_POS) ? mix_pos_q :
		(bus.addr == `OFS_MIXER_BIAS_NEG) ? mix_neg_q : 8'h00;

	assign bus.rdata = rdata_q;
	assign bus.rvalid = rvalid_q;

	// Pin drive; enable is active low while driving
	wire [2:0] pin_dir = pin_cfg_q[`PIN_DIR_HI:`PIN_DIR_LO];
	assign pin_out_o = pin_out_q[`PIN_VAL_HI:`PIN_VAL_LO];
	assign pin_oe_n_o = ~pin_dir;
	assign pin_level_18v_o = pin_cfg_q[`PIN_LVL_HI:`PIN_LVL_LO];
	assign detector_cal_trim_o = det_trim_q[4:0];
	assign if_amp_bias_level_o = if_bias_q[3:0];
	assign rf_output_driver_bias_o = rf_bias_q[7:4];
	assign rf_predriver_bias_o = rf_bias_q[3:0];
	assign lo_amp_bias_first_o = lo_bias_q[3:0];
	assign lo_amp_bias_second_o = lo_bias_q[7:4];
	assign mixer_bias_positive_o = mix_pos_q[4:0];
	assign mixer_bias_negative_o = mix_neg_q[4:0];

	always_comb begin
		conv_d = conv_q;
		case (conv_q)
			bank_pkg::CONV_IDLE: begin
				if (conv_go) begin
					conv_d = bank_pkg::CONV_BUSY;
				end
			end
			bank_pkg::CONV_BUSY: begin
				if (conv_done) begin
					conv_d = bank_pkg::CONV_IDLE;
				end
			end
			default: conv_d = bank_pkg::CONV_IDLE;
		endcase
	end

	// Register writes, masked so reserved bits stay zero
	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			ctl_q <= `RST_CONVERTER_CONTROL;
			pin_out_q <= `RST_PIN_OUTPUT_VALUES;
			pin_cfg_q <= `RST_PIN_DIRECTION_LEVEL;
			if_bias_q <= `RST_IF_AMP_BIAS;
			rf_bias_q <= `RST_RF_DRIVER_BIAS;
			lo_bias_q <= `RST_LO_AMP_BIAS;
			det_trim_q <= `RST_DETECTOR_TRIM;
			mix_pos_q <= `RST_MIXER_BIAS_POS;
			mix_neg_q <= `RST_MIXER_BIAS_NEG;
		end else begin
			if (wr_ctl) ctl_q <= masked_write(ctl_q, bus.wdata, `WMASK_CONVERTER_CONTROL);
			if (wr_pin_out) pin_out_q <= masked_write(pin_out_q, bus.wdata, `WMASK_PIN_OUTPUT_VALUES);
			if (wr_pin_cfg) pin_cfg_q <= masked_write(pin_cfg_q, bus.wdata, `WMASK_PIN_DIRECTION_LEVEL);
			if (wr_if_bias) if_bias_q <= masked_write(if_bias_q, bus.wdata, `WMASK_IF_AMP_BIAS);
			if (wr_rf_bias) rf_bias_q <= masked_write(rf_bias_q, bus.wdata, `WMASK_RF_DRIVER_BIAS);
			if (wr_lo_bias) lo_bias_q <= masked_write(lo_bias_q, bus.wdata, `WMASK_LO_AMP_BIAS);
			if (wr_det) det_trim_q <= masked_write(det_trim_q, bus.wdata, `WMASK_DETECTOR_TRIM);
			if (wr_mix_pos) mix_pos_q <= masked_write(mix_pos_q, bus.wdata, `WMASK_MIXER_BIAS);
			if (wr_mix_neg) mix_neg_q <= masked_write(mix_neg_q, bus.wdata, `WMASK_MIXER_BIAS);
		end
	end

	// Read answer one cycle after the request
	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			rdata_q <= 8'h00;
			rvalid_q <= 1'b0;
		end else begin
			rvalid_q <= bus.rd_en;
			if (bus.rd_en) rdata_q <= rd_mux;
		end
	end

	// Pin sampling
	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			pin_in_q <= `RST_PIN_INPUT_FIELD;
		end else begin
			pin_in_q <= pin_in_i;
		end
	end

	// Converter sequencing
	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			conv_q <= bank_pkg::CONV_IDLE;
			start_prev_q <= 1'b1;
			ready_q <= 1'b0;
			result_q <= `RST_CONVERTER_RESULT;
			sample_q <= 8'h00;
			div_cnt_q <= 5'h00;
			conv_cnt_q <= 4'h0;
		end else begin
			conv_q <= conv_d;
			start_prev_q <= start_bit;
			if (conv_go) begin
				sample_q <= conv_sample_i;
				div_cnt_q <= 5'h00;
				conv_cnt_q <= 4'h0;
			end else if (busy) begin
				div_cnt_q <= conv_tick ? 5'h00 : div_cnt_q + 5'h01;
				if (conv_tick) conv_cnt_q <= conv_cnt_q + 4'h1;
			end
			if (conv_done) begin
				result_q <= conv_value;
				ready_q <= 1'b1;
			end else if (conv_go) begin
				ready_q <= 1'b0;
			end
		end
	end
endmodule

`default_nettype wire

/* bench/bank_link_properties.sv */
// Purpose: Link-level checks between host end and device end of the register bank
// Assumes: One clock, synchronous active-high reset
// Notes: Sees only the link signals
`include "bank_consts.svh"
`default_nettype none

module bank_link_checker (
	input wire logic ref_clk_i,
	input wire logic rst_i,
	input wire logic wr_en,
	input wire logic rd_en,
	input wire logic [`ADDR_W-1:0] addr,
	input wire logic [`DATA_W-1:0] wdata,
	input wire logic [`DATA_W-1:0] rdata,
	input wire logic rvalid
);
	default clocking cb @(posedge ref_clk_i);
	endclocking
	default disable iff (rst_i);

	property p_read_answer;
		rd_en |=> rvalid;
	endproperty
	a_read_answer: assert property (p_read_answer) else $error("read not answered next cycle");
	property p_answer_cause;
		rvalid |-> $past(rd_en);
	endproperty
	a_answer_cause: assert property (p_answer_cause) else $error("answer without read");
	property p_write_silent;
		wr_en && !rd_en |=> !rvalid;
	endproperty
	a_write_silent: assert property (p_write_silent) else $error("write answered");
	property p_unmapped_zero;
		rd_en && (addr < 12'h302 || addr > 12'h30E || addr == 12'h30B) |=> rdata == 8'h00;
	endproperty
	a_unmapped_zero: assert property (p_unmapped_zero) else $error("unmapped read not zero");
	property p_pin_reserved;
		rd_en && (addr == 12'h305 || addr == 12'h306) |=> rdata[7:4] == 4'h0 && !rdata[0];
	endproperty
	a_pin_reserved: assert property (p_pin_reserved) else $error("pin reserved bits set");
	property p_trim_reserved;
		rd_en && addr >= 12'h30C && addr <= 12'h30E |=> rdata[7:5] == 3'h0;
	endproperty
	a_trim_reserved: assert property (p_trim_reserved) else $error("trim reserved bits set");
	property p_status_consistent;
		rd_en && addr == 12'h303 |=> rdata[7:3] == 5'h00 && rdata[0] == !rdata[1] && !(rdata[1] && rdata[2]);
	endproperty
	a_status_consistent: assert property (p_status_consistent) else $error("status flags clash");
	property p_dir_writeback;
		wr_en && addr == 12'h307 ##1 rd_en && addr == 12'h307 |=> rdata == ($past(wdata, 2) & 8'h7E);
	endproperty
	a_dir_writeback: assert property (p_dir_writeback) else $error("pin control readback wrong");
	property p_trim_writeback;
		wr_en && addr == 12'h30C ##1 rd_en && addr == 12'h30C |=> rdata == ($past(wdata, 2) & 8'h1F);
	endproperty
	a_trim_writeback: assert property (p_trim_writeback) else $error("trim readback wrong");
endmodule

`default_nettype wire

/* bench/adc_gpio_trim_registers_tb_top.sv */
// Purpose: Host end and device end joined on the link, driven from the command port
// Assumes: Read answers appear on rsp_valid_o in request order
// Notes: Pin wire resolved from device enables and a bench driver
`include "bank_consts.svh"
`default_nettype none

module adc_gpio_trim_registers_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic ref_clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic cmd_valid_i = 1'b0;
	logic cmd_write_i = 1'b0;
	bank_pkg::reg_addr_t cmd_addr_i = 12'h000;
	bank_pkg::reg_data_t cmd_wdata_i = 8'h00;
	bank_pkg::reg_data_t conv_sample_i = 8'h00;
	logic [2:0] ext_pins = 3'h7;
	wire logic [2:0] pin_in_i;
	logic cmd_ready_o, rsp_valid_o;
	bank_pkg::reg_data_t rsp_data_o;
	logic [2:0] pin_out_o, pin_oe_n_o, pin_level_18v_o;
	logic [4:0] detector_cal_trim_o, mixer_bias_positive_o, mixer_bias_negative_o;
	logic [3:0] if_amp_bias_level_o, rf_output_driver_bias_o, rf_predriver_bias_o;
	logic [3:0] lo_amp_bias_first_o, lo_amp_bias_second_o;
	int miscompares = 0;
	int tests_run = 0;
	int cycles = 0;
	int seed = 32'hBF49;
	bank_pkg::reg_data_t exp_q[$];
	bank_pkg::reg_data_t d[13];
	// Indexed by offset minus 0x302; index 9 is the unmapped hole
	bank_pkg::reg_data_t rst_v[13] = '{8'hCA, 8'h01, 8'hEF, 8'h00, 8'h0E, 8'h00, 8'h08, 8'h88, 8'h88, 8'h00,
		8'h00, 8'h08, 8'h08};
	bank_pkg::reg_data_t wm[13] = '{8'hFF, 8'h00, 8'h00, 8'h0E, 8'h00, 8'h7E, 8'h0F, 8'hFF, 8'hFF, 8'h00,
		8'h1F, 8'h1F, 8'h1F};

	bank_if link();
	assign pin_in_i = (~pin_oe_n_o & pin_out_o) | (pin_oe_n_o & ext_pins);

	bank_host u_bank_host(.ref_clk_i, .rst_i, .bus(link), .cmd_valid_i, .cmd_write_i, .cmd_addr_i, .cmd_wdata_i,
		.cmd_ready_o, .rsp_valid_o, .rsp_data_o);
	bank_device u_bank_device(.ref_clk_i, .rst_i, .bus(link), .conv_sample_i, .pin_in_i, .pin_out_o, .pin_oe_n_o,
		.pin_level_18v_o, .detector_cal_trim_o, .if_amp_bias_level_o, .rf_output_driver_bias_o, .rf_predriver_bias_o,
		.lo_amp_bias_first_o, .lo_amp_bias_second_o, .mixer_bias_positive_o, .mixer_bias_negative_o);
	bank_link_checker u_bank_link_checker(.ref_clk_i, .rst_i, .wr_en(link.wr_en), .rd_en(link.rd_en),
		.addr(link.addr), .wdata(link.wdata), .rdata(link.rdata), .rvalid(link.rvalid));

	always #5 ref_clk_i = ~ref_clk_i;

	task automatic give_verdict();
		$display("comparisons %0d mismatches %0d", tests_run, miscompares);
		if (miscompares == 0 && tests_run > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask

	task automatic chk(input bank_pkg::reg_data_t got, input bank_pkg::reg_data_t exp);
		tests_run++;
		if (got !== exp) begin
			miscompares++;
			$display("MISMATCH %0t got %h expected %h", $time, got, exp);
		end
	endtask

	// For a read, v is the expected answer
	task automatic send(input logic w, input bank_pkg::reg_addr_t a, input bank_pkg::reg_data_t v, input logic last);
		while (cmd_ready_o !== 1'b1) begin
			@(posedge ref_clk_i);
			#1;
		end
		cmd_valid_i = 1'b1;
		cmd_write_i = w;
		cmd_addr_i = a;
		cmd_wdata_i = v;
		if (!w) begin
			exp_q.push_back(v);
		end
		@(posedge ref_clk_i);
		#1;
		if (last) begin
			cmd_valid_i = 1'b0;
			@(posedge ref_clk_i);
			#1;
		end
	endtask

	task automatic conv(input bank_pkg::reg_data_t ctl, input bank_pkg::reg_data_t res);
		send(1'b1, 12'h302, ctl & 8'hFD, 1'b1);
		send(1'b1, 12'h302, ctl, 1'b1);
		repeat (24) @(posedge ref_clk_i);
		#1;
		send(1'b0, 12'h303, 8'h02, 1'b1);
		conv_sample_i = ~conv_sample_i;
		repeat (12) @(posedge ref_clk_i);
		#1;
		send(1'b0, 12'h303, 8'h05, 1'b1);
		send(1'b1, 12'h302, ctl, 1'b1);
		send(1'b0, 12'h303, 8'h05, 1'b1);
		send(1'b0, 12'h304, res, 1'b1);
	endtask

	always @(negedge ref_clk_i) begin
		if (rsp_valid_o === 1'b1) begin
			if (exp_q.size() == 0) begin
				miscompares++;
				$display("MISMATCH %0t unexpected answer", $time);
			end else begin
				chk(rsp_data_o, exp_q.pop_front());
			end
		end
	end

	always @(posedge ref_clk_i) begin
		cycles++;
		if (cycles == 4000) begin
			miscompares++;
			give_verdict();
		end
	end

	initial begin
		repeat (3) @(posedge ref_clk_i);
		#1;
		rst_i = 1'b0;
		for (int i = 0; i < 13; i++) begin
			send(1'b0, 12'(12'h302 + i), rst_v[i], 1'b1);
		end
		$display("test reset values done");
		for (int i = 0; i < 13; i++) begin
			d[i] = 8'($random(seed));
			send(1'b1, 12'(12'h302 + i), d[i], 1'b0);
			send(1'b0, 12'(12'h302 + i), (d[i] & wm[i]) | (rst_v[i] & ~wm[i]), 1'b1);
		end
		chk({5'h00, pin_out_o}, {5'h00, d[3][3:1]});
		chk({2'h0, pin_oe_n_o, pin_level_18v_o}, {2'h0, ~d[5][6:4], d[5][3:1]});
		chk({3'h0, detector_cal_trim_o}, d[10] & 8'h1F);
		chk({4'h0, if_amp_bias_level_o}, d[6] & 8'h0F);
		chk({rf_output_driver_bias_o, rf_predriver_bias_o}, d[7]);
		chk({lo_amp_bias_second_o, lo_amp_bias_first_o}, d[8]);
		chk({3'h0, mixer_bias_positive_o}, d[11] & 8'h1F);
		chk({3'h0, mixer_bias_negative_o}, d[12] & 8'h1F);
		$display("test access done");
		ext_pins = 3'($random(seed));
		send(1'b0, 12'h306, {4'h0, (d[3][3:1] & d[5][6:4]) | (ext_pins & ~d[5][6:4]), 1'b0}, 1'b1);
		send(1'b1, 12'h308, 8'h08, 1'b1);
		send(1'b1, 12'h309, 8'h00, 1'b1);
		send(1'b1, 12'h30A, 8'h00, 1'b1);
		send(1'b1, 12'h30D, 8'h09, 1'b1);
		send(1'b1, 12'h30E, 8'h09, 1'b1);
		chk({4'h0, if_amp_bias_level_o}, 8'h08);
		chk({rf_output_driver_bias_o, rf_predriver_bias_o}, 8'h00);
		chk({lo_amp_bias_second_o, lo_amp_bias_first_o}, 8'h00);
		chk({3'h0, mixer_bias_positive_o}, 8'h09);
		chk({3'h0, mixer_bias_negative_o}, 8'h09);
		$display("test pins and bias done");
		send(1'b1, 12'h302, 8'h20, 1'b1);
		send(1'b1, 12'h302, 8'h22, 1'b1);
		send(1'b0, 12'h303, 8'h01, 1'b1);
		conv_sample_i = 8'($random(seed)) | 8'h80;
		conv(8'h27, {1'b0, conv_sample_i[7:1]});
		conv_sample_i = 8'($random(seed)) | 8'h80;
		conv(8'h2B, {3'h7, conv_sample_i[6:2]});
		$display("test conversion done");
		repeat (6) @(posedge ref_clk_i);
		if (exp_q.size() != 0) begin
			miscompares++;
			$display("MISMATCH %0t answers missing", $time);
		end
		give_verdict();
	end
endmodule

`default_nettype wire
